// >>> core/lrs_ctrl.sv
// top of the line rate switch controller: triggers, flow, registers
`timescale 1ns/1ps
module lrs_ctrl import lrs_pkg::*; #(
  parameter bit NEG_TRAIN_EN = 1'b1, // negotiation and training option
  parameter bit REG_IF_EN = 1'b1 // register interface option
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rate_sel_in,
  input wire logic mode_change_in,
  input lrs_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic drp_rdy,
  output lrs_drp_req_t drp_req,
  input wire logic reconfig_done_in,
  input wire logic an_done_in,
  input wire logic lt_done_in,
  output logic rate_switch_out,
  output logic rate_mode_out,
  output logic rate_40g_out,
  output logic xcvr_rst_out,
  output logic core_rst_out,
  output logic busy_out,
  output logic neg_done_out,
  output logic [31:0] user_defined_word
);
  typedef enum logic [1:0] {LS_IDLE, LS_RECONF, LS_WAIT_DONE, LS_CORE_RST} lrs_st_t;
  lrs_st_t st_r, st_nxt; // flow state
  logic [2:0] hist_r, hist_nxt; // past request samples
  logic tgt_r, tgt_nxt; // target rate, 1 = 40G
  logic rate_r, rate_nxt; // active rate
  logic xrst_r, xrst_nxt; // transceiver reset
  logic crst_r, crst_nxt; // core reset
  logic [LRS_CNT_W-1:0] cnt_r, cnt_nxt; // core reset length
  logic sw_r, sw_nxt; // switch pulse
  logic neg_r, neg_nxt; // negotiation done
  logic [31:0] user_r, user_nxt; // user register
  logic [31:0] rd_r, rd_nxt; // read data
  logic pin_trig; // request pattern seen
  logic reg_trig; // trigger register written with one
  logic seq_start; // start the write sequencer
  logic seq_done; // writes finished
  logic neg_both; // both completions present

  // two-high-then-low pattern on the request input [RQ3]
  assign pin_trig = ({hist_r, mode_change_in} == LRS_REQ_PAT);
  // write one to the self-clearing trigger [RQ2]
  assign reg_trig = REG_IF_EN && reg_req.wr_en && (reg_req.addr == LRS_OFF_TRIG)
                    && reg_req.wdata[LRS_TRIG_BIT];
  // new request only taken in idle, either direction [RQ7] [RQ12]
  assign seq_start = (st_r == LS_IDLE) && (pin_trig || reg_trig);
  assign neg_both = an_done_in && lt_done_in;

  // channel write sequencer
  lrs_drp_seq u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(seq_start),
    .rate_40g(tgt_nxt),
    .drp_rdy(drp_rdy),
    .drp_req(drp_req),
    .done(seq_done)
  );

  // flow next state
  always_comb begin
    st_nxt = st_r;
    hist_nxt = {hist_r[1:0], mode_change_in};
    tgt_nxt = tgt_r;
    rate_nxt = rate_r;
    xrst_nxt = xrst_r;
    crst_nxt = crst_r;
    cnt_nxt = cnt_r;
    sw_nxt = 1'b0;
    case (st_r)
      LS_IDLE: begin
        if (seq_start) begin
          tgt_nxt = rate_sel_in ? LRS_RATE_40G : LRS_RATE_50G; // [RQ1]
          sw_nxt = reg_trig; // [RQ2]
          xrst_nxt = 1'b1;
          st_nxt = LS_RECONF;
        end
      end
      LS_RECONF: begin
        // writes done: present the new rate to the core [RQ11]
        if (seq_done) begin
          rate_nxt = tgt_r;
          st_nxt = LS_WAIT_DONE;
        end
      end
      LS_WAIT_DONE: begin
        // release transceiver reset and start core reset in the same cycle [RQ10] [RQ4]
        if (reconfig_done_in) begin
          xrst_nxt = 1'b0;
          crst_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = LS_CORE_RST;
        end
      end
      LS_CORE_RST: begin
        // hold core reset for the set length [RQ4]
        if (cnt_r == LRS_CNT_W'(LRS_CORE_RST_CYC - 1)) begin
          crst_nxt = 1'b0;
          st_nxt = LS_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: st_nxt = LS_IDLE;
    endcase
  end

  // flow registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= LS_IDLE;
      hist_r <= '0;
      tgt_r <= LRS_RATE_RST;
      rate_r <= LRS_RATE_RST;
      xrst_r <= 1'b0;
      crst_r <= 1'b0;
      cnt_r <= '0;
      sw_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      hist_r <= hist_nxt;
      tgt_r <= tgt_nxt;
      rate_r <= rate_nxt;
      xrst_r <= xrst_nxt;
      crst_r <= crst_nxt;
      cnt_r <= cnt_nxt;
      sw_r <= sw_nxt;
    end
  end

  // register port and status next values
  always_comb begin
    user_nxt = user_r;
    rd_nxt = rd_r;
    neg_nxt = NEG_TRAIN_EN && neg_both; // [RQ8]
    if (REG_IF_EN && reg_req.wr_en && (reg_req.addr == LRS_OFF_USER)) begin
      user_nxt = reg_req.wdata; // [RQ9]
    end
    if (reg_req.rd_en) begin
      rd_nxt = 32'h0000_0000; // trigger and unmapped read zero [RQ2]
      if (REG_IF_EN && (reg_req.addr == LRS_OFF_USER)) begin
        rd_nxt = user_r;
      end else if (REG_IF_EN && (reg_req.addr == LRS_OFF_STAT)) begin
        rd_nxt[LRS_ST_BUSY] = (st_r != LS_IDLE);
        rd_nxt[LRS_ST_RATE] = rate_r;
        rd_nxt[LRS_ST_NEG] = neg_r;
        rd_nxt[LRS_ST_XRST] = xrst_r;
      end
    end
  end

  // register port registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_r <= LRS_USER_RST;
      rd_r <= 32'h0000_0000;
      neg_r <= 1'b0;
    end else begin
      user_r <= user_nxt;
      rd_r <= rd_nxt;
      neg_r <= neg_nxt;
    end
  end

  assign reg_rdata = rd_r;
  assign rate_switch_out = sw_r;
  assign rate_mode_out = rate_r; // [RQ11]
  assign rate_40g_out = rate_r;
  assign xcvr_rst_out = xrst_r;
  assign core_rst_out = crst_r;
  assign busy_out = (st_r != LS_IDLE);
  assign neg_done_out = neg_r;
  assign user_defined_word = user_r;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_pin_req_start: assert property (pin_trig && !busy_out |=> busy_out && xcvr_rst_out) // [RQ3]
    else $error("request pattern did not start a switch");
  a_reg_trig_pulse: assert property (reg_trig && !busy_out |=> rate_switch_out ##1 !rate_switch_out) // [RQ2]
    else $error("trigger write did not give one switch pulse");
  a_rate_select_map: assert property (seq_start |=> tgt_r == $past(rate_sel_in)) // [RQ1]
    else $error("target rate does not follow rate select");
  a_busy_ignore_req: assert property (busy_out |=> $stable(tgt_r) && !rate_switch_out) // [RQ12]
    else $error("request taken while busy");
  a_core_rst_follow: assert property (st_r == LS_WAIT_DONE && reconfig_done_in // [RQ4]
    |=> core_rst_out && !xcvr_rst_out)
    else $error("core reset did not follow reconfig done");
  // core reset stands ten cycles: eight, two more, then drops
  a_core_rst_len: assert property ($rose(core_rst_out) |-> core_rst_out[*8] // [RQ4]
    ##1 core_rst_out ##1 core_rst_out ##1 !core_rst_out)
    else $error("core reset length wrong");
  a_xrst_held: assert property ($rose(xcvr_rst_out) |-> xcvr_rst_out until reconfig_done_in) // [RQ10]
    else $error("transceiver reset dropped early");
  a_mode_after_writes: assert property (seq_done && st_r == LS_RECONF |=> rate_mode_out == tgt_r) // [RQ11]
    else $error("rate mode not updated after writes");
  a_neg_done_both: assert property (##1 neg_done_out == (NEG_TRAIN_EN && $past(neg_both))) // [RQ8]
    else $error("negotiation done mismatch");
  a_user_word_follow: assert property (REG_IF_EN && reg_req.wr_en // [RQ9]
    && reg_req.addr == LRS_OFF_USER |=> user_defined_word == $past(reg_req.wdata))
    else $error("user word not updated");
  a_trig_reads_zero: assert property (reg_req.rd_en && reg_req.addr == LRS_OFF_TRIG |=> reg_rdata == 32'h0000_0000) // [RQ2]
    else $error("trigger register did not read zero");
  // transceiver reset only lets go on the done input
  a_xrst_release: assert property ($fell(xcvr_rst_out) |-> $past(reconfig_done_in)) // [RQ10]
    else $error("transceiver reset released without done");
  // back to idle in the cycle the core reset ends
  a_idle_after_rst: assert property ($fell(core_rst_out) |-> !busy_out) // [RQ12]
    else $error("still busy after core reset");
  // channel writes only inside a running switch
  a_write_in_switch: assert property (drp_req.en |-> busy_out && xcvr_rst_out && drp_req.we) // [RQ5]
    else $error("channel write outside a switch");

  c_switch_40g: cover property ($fell(core_rst_out) && rate_40g_out);
  c_switch_50g: cover property ($fell(core_rst_out) && !rate_40g_out);
  c_busy_request: cover property (busy_out && (pin_trig || reg_trig));
  c_reg_trigger: cover property (rate_switch_out);
endmodule

// >>> core/lrs_pkg.sv
// package for the line rate switch controller: offsets, timings, tables, carriers
// Functional notes
// [RQ1] rate select high means 40G, low 50G
// [RQ2] write one at 0x013C triggers switch, self-clears
// [RQ3] request high two cycles then low starts writes
// [RQ4] after reconfiguration writes, reset the affected core
// [RQ5] writes go to transceiver channel only
// [RQ6] PLLs fixed; switch only selects between them
// [RQ7] switching accepted both directions when idle
// [RQ8] negotiation done when negotiation and training done
// [RQ9] user word output mirrors user register
// [RQ10] reconfig done input releases transceiver reset
// [RQ11] rate mode output: zero 50G, one 40G
// [RQ12] ignore requests until writes and reset finish
package lrs_pkg;
  // register offsets on the register port
  localparam logic [15:0] LRS_OFF_TRIG = 16'h013C;
  localparam logic [15:0] LRS_OFF_USER = 16'h0140;
  localparam logic [15:0] LRS_OFF_STAT = 16'h0144;
  // bit positions
  localparam int LRS_TRIG_BIT = 0;
  localparam int LRS_ST_BUSY = 0;
  localparam int LRS_ST_RATE = 1;
  localparam int LRS_ST_NEG = 2;
  localparam int LRS_ST_XRST = 3;
  // values after reset
  localparam logic [31:0] LRS_USER_RST = 32'h0000_0000;
  localparam logic LRS_RATE_RST = 1'b0;
  // rate encodings
  localparam logic LRS_RATE_40G = 1'b1;
  localparam logic LRS_RATE_50G = 1'b0;
  // timing
  localparam int LRS_CLK_PERIOD_NS = 10;
  localparam int LRS_CORE_RST_NS = 100;
  localparam int LRS_CORE_RST_CYC = (LRS_CORE_RST_NS + LRS_CLK_PERIOD_NS - 1) / LRS_CLK_PERIOD_NS;
  localparam int LRS_CNT_W = 4;
  // request pattern: low, high, high, then low now
  localparam logic [3:0] LRS_REQ_PAT = 4'h6;
  // channel write table: clock select fields only, per rate
  localparam int LRS_N_WR = 4;
  localparam logic [1:0] LRS_LAST_IDX = 2'h3;
  localparam logic [9:0] LRS_DRP_ADDR [LRS_N_WR] = '{10'h010, 10'h011, 10'h012, 10'h013};
  localparam logic [15:0] LRS_DRP_D40 [LRS_N_WR] = '{16'h0002, 16'h0002, 16'h0003, 16'h0003};
  localparam logic [15:0] LRS_DRP_D50 [LRS_N_WR] = '{16'h0003, 16'h0003, 16'h0002, 16'h0002};
  // channel reconfiguration port request
  typedef struct packed {
    logic en;
    logic we;
    logic [9:0] addr;
    logic [15:0] di;
  } lrs_drp_req_t;
  // register port request
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [15:0] addr;
    logic [31:0] wdata;
  } lrs_reg_req_t;
endpackage

// >>> core/lrs_drp_seq.sv
// channel reconfiguration write sequencer
`timescale 1ns/1ps
module lrs_drp_seq import lrs_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic rate_40g,
  input wire logic drp_rdy,
  output lrs_drp_req_t drp_req,
  output logic done
);
  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT, SQ_DONE} lrs_sq_t;
  lrs_sq_t st_r, st_nxt; // sequencer state
  logic [1:0] idx_r, idx_nxt; // table entry
  logic rate_r, rate_nxt; // target rate of this run
  lrs_drp_req_t req_r, req_nxt; // registered request
  logic done_r, done_nxt; // one-cycle completion

  // next state: one write per entry, wait each acknowledge
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    rate_nxt = rate_r;
    req_nxt = '0;
    done_nxt = 1'b0;
    case (st_r)
      SQ_IDLE: begin
        if (start) begin
          idx_nxt = '0;
          rate_nxt = rate_40g;
          st_nxt = SQ_ISSUE;
        end
      end
      SQ_ISSUE: begin
        // only channel addresses, clock select values; no common retune [RQ5] [RQ6]
        req_nxt.en = 1'b1;
        req_nxt.we = 1'b1;
        req_nxt.addr = LRS_DRP_ADDR[idx_r];
        req_nxt.di = rate_r ? LRS_DRP_D40[idx_r] : LRS_DRP_D50[idx_r];
        st_nxt = SQ_WAIT;
      end
      SQ_WAIT: begin
        if (drp_rdy) begin
          if (idx_r == LRS_LAST_IDX) begin
            st_nxt = SQ_DONE;
          end else begin
            idx_nxt = idx_r + 2'h1;
            st_nxt = SQ_ISSUE;
          end
        end
      end
      SQ_DONE: begin
        done_nxt = 1'b1;
        st_nxt = SQ_IDLE;
      end
      default: st_nxt = SQ_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SQ_IDLE;
      idx_r <= '0;
      rate_r <= 1'b0;
      req_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      rate_r <= rate_nxt;
      req_r <= req_nxt;
      done_r <= done_nxt;
    end
  end

  assign drp_req = req_r;
  assign done = done_r;
endmodule

// >>> tb/lrs_drp_model.sv
// behavioural channel reconfiguration port with done source
`timescale 1ns/1ps
module lrs_drp_model import lrs_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input lrs_drp_req_t drp_req,
  input wire logic slow,
  output logic drp_rdy,
  output logic reconfig_done_in
);
  int wait_c; // cycles left before acknowledge
  int n_wr; // writes acknowledged in this switch
  int done_c; // cycles left before done pulse
  // acknowledge each write, promptly or slowly, then signal done
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drp_rdy <= 1'b0;
      reconfig_done_in <= 1'b0;
      wait_c <= -1;
      n_wr <= 0;
      done_c <= -1;
    end else begin
      drp_rdy <= 1'b0;
      reconfig_done_in <= 1'b0;
      if (drp_req.en) begin
        wait_c <= slow ? 5 : 0;
      end else if (wait_c == 0) begin
        drp_rdy <= 1'b1;
        wait_c <= -1;
        n_wr <= n_wr + 1;
        if (n_wr == LRS_N_WR - 1) done_c <= 8;
      end else if (wait_c > 0) begin
        wait_c <= wait_c - 1;
      end
      // done only after the last write has been acknowledged
      if (done_c == 0) begin
        reconfig_done_in <= 1'b1;
        n_wr <= 0;
      end
      if (done_c >= 0) done_c <= done_c - 1;
    end
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the line rate switch controller
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module tb import lrs_pkg::*; ;
  logic ref_clk, rst_n, rate_sel_in, mode_change_in, drp_rdy, reconfig_done_in;
  logic an_done_in, lt_done_in, slow, rate_switch_out, rate_mode_out, rate_40g_out;
  logic xcvr_rst_out, core_rst_out, busy_out, neg_done_out;
  logic [31:0] reg_rdata, user_defined_word, rnd;
  logic [25:0] exp_w; // popped expected write
  lrs_reg_req_t reg_req;
  lrs_drp_req_t drp_req;
  int n_fail, n_checks, n_rst;
  logic [25:0] exp_q[$]; // expected channel writes, address then data
  lrs_ctrl lrs_ctrl_inst (.ref_clk, .rst_n, .rate_sel_in, .mode_change_in, .reg_req,
    .reg_rdata, .drp_rdy, .drp_req, .reconfig_done_in, .an_done_in, .lt_done_in,
    .rate_switch_out, .rate_mode_out, .rate_40g_out, .xcvr_rst_out, .core_rst_out,
    .busy_out, .neg_done_out, .user_defined_word);
  lrs_drp_model lrs_drp_model_inst (.ref_clk, .rst_n, .drp_req, .slow, .drp_rdy,
    .reconfig_done_in);
  // clock, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // every channel write must match the next expected one
  always @(posedge ref_clk) begin
    if (drp_req.en === 1'b1) begin
      `CHK("drp_we", 1'b1, drp_req.we)
      if (exp_q.size() == 0) begin
        `CHK("extra_write", 1'b0, 1'b1)
      end else begin
        exp_w = exp_q.pop_front();
        `CHK("drp_write", exp_w, {drp_req.addr, drp_req.di})
      end
    end
  end
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one register access, strobe for a single cycle
  task automatic reg_op(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(negedge ref_clk) reg_req <= '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
    @(negedge ref_clk) reg_req <= '0;
  endtask
  // request pin: high two cycles then low
  task automatic pin_trig();
    @(negedge ref_clk) mode_change_in <= 1'b1;
    repeat (2) @(negedge ref_clk);
    mode_change_in <= 1'b0;
  endtask
  // full switch, with retriggers while busy that must be ignored
  task automatic do_switch(input logic by_reg, input logic rate);
    logic [31:0] st_exp; // expected status word
    rate_sel_in <= rate;
    for (int k = 0; k < LRS_N_WR; k++)
      exp_q.push_back({LRS_DRP_ADDR[k], rate ? LRS_DRP_D40[k] : LRS_DRP_D50[k]});
    if (by_reg) begin
      reg_op(1'b1, LRS_OFF_TRIG, 32'h0000_0001);
    end else begin
      pin_trig();
      @(negedge ref_clk);
    end
    `CHK("switch_pulse", by_reg, rate_switch_out)
    `CHK("busy", 1'b1, busy_out)
    `CHK("xcvr_rst", 1'b1, xcvr_rst_out)
    // status while busy: old rate still active, transceiver in reset
    st_exp = (32'(1'b1) << LRS_ST_BUSY) | (32'(1'b1) << LRS_ST_XRST);
    st_exp |= (32'(!rate) << LRS_ST_RATE) | (32'(an_done_in & lt_done_in) << LRS_ST_NEG);
    reg_op(1'b0, LRS_OFF_STAT, 32'h0000_0000);
    `CHK("status_busy", st_exp, reg_rdata)
    reg_op(1'b1, LRS_OFF_TRIG, 32'h0000_0001);
    `CHK("busy_pulse", 1'b0, rate_switch_out)
    pin_trig();
    n_rst = 0;
    for (int t = 0; t < 400 && busy_out !== 1'b0; t++) begin
      @(negedge ref_clk);
      n_rst += int'(core_rst_out === 1'b1);
      if (core_rst_out === 1'b1) `CHK("xcvr_rel", 1'b0, xcvr_rst_out)
    end
    if (busy_out !== 1'b0) begin
      `CHK("switch_end", 1'b0, busy_out)
      stop_test();
    end
    `CHK("core_rst_len", LRS_CORE_RST_CYC, n_rst)
    // status when idle again: new rate, no reset, not busy
    st_exp = (32'(rate) << LRS_ST_RATE) | (32'(an_done_in & lt_done_in) << LRS_ST_NEG);
    reg_op(1'b0, LRS_OFF_STAT, 32'h0000_0000);
    `CHK("status_idle", st_exp, reg_rdata)
    `CHK("rate_mode", rate, rate_mode_out)
    `CHK("rate_40g", rate, rate_40g_out)
    `CHK("writes_left", 0, exp_q.size())
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    rate_sel_in = 1'b0;
    mode_change_in = 1'b0;
    an_done_in = 1'b0;
    lt_done_in = 1'b0;
    slow = 1'b0;
    reg_req = '0;
    rnd = 32'h2bcd_6374;
    n_fail = 0;
    n_checks = 0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK("rst_rate", LRS_RATE_50G, rate_mode_out)
    `CHK("rst_busy", 1'b0, busy_out)
    // negotiation done follows both inputs
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      @(negedge ref_clk);
      an_done_in <= rnd[0] | i[0];
      lt_done_in <= rnd[1] | i[0];
      @(negedge ref_clk);
      `CHK("neg_done", an_done_in & lt_done_in, neg_done_out)
    end
    // user register mirrored on the output word
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      reg_op(1'b1, LRS_OFF_USER, rnd);
      reg_op(1'b0, LRS_OFF_USER, 32'h0000_0000);
      `CHK("user_rd", rnd, reg_rdata)
      `CHK("user_word", rnd, user_defined_word)
    end
    reg_op(1'b0, 16'h0200, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, reg_rdata)
    reg_op(1'b0, LRS_OFF_TRIG, 32'h0000_0000);
    `CHK("trig_rd", 32'h0000_0000, reg_rdata)
    // both directions, both triggers, prompt and slow port
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      do_switch(i == 0 || i == 3, !i[0]);
    end
    reg_op(1'b0, LRS_OFF_TRIG, 32'h0000_0000);
    `CHK("trig_clear", 32'h0000_0000, reg_rdata)
    stop_test();
  end
endmodule
